// ===== design/asr_defines.vh
// constants for the audio serial input receiver
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH
// framing select codes
`define ASR_FMT_I2S 2'h0
`define ASR_FMT_LJ 2'h1
`define ASR_FMT_RJ 2'h2
// word length select codes
`define ASR_WL_16 2'h0
`define ASR_WL_20 2'h1
`define ASR_WL_24 2'h2
// word lengths in bits
`define ASR_BITS_16 6'h10
`define ASR_BITS_20 6'h14
`define ASR_BITS_24 6'h18
// output sample width
`define ASR_OUT_W 24
// slot counter width (up to 63 bits per slot)
`define ASR_CNT_W 6
`endif

// ===== design/asr_receiver.v
// two-channel serial audio receiver for i2s, left- and right-justified frames
// Behaviour
// - accept 16/20/24-bit words, three framings
// - i2s: frame clock low is left
// - handle 32, 48, 64 bit clocks per frame
// - i2s: msb one bit clock after edge
// - msb first, sampled on bit clock rise
// - i2s and lj: ignore trailing slot bits
// - lj and rj: frame clock high is left
// - lj: msb in same period as edge
// - rj 24-bit at 64 per frame: msb eight periods after edge
// - rj: lsb is last period before edge
// - rj: ignore leading slot bits
// - samples are signed two's complement
// - 48 per frame: 24-bit slot word
`timescale 1ns/10ps
`default_nettype none
`include "asr_defines.vh"
module asr_receiver #(
  parameter OUT_W = `ASR_OUT_W,
  parameter CNT_W = `ASR_CNT_W
) (
  input wire clock,
  input wire reset_n,
  input wire clock_enable,
  input wire [1:0] format_sel,
  input wire [1:0] word_len_sel,
  input wire bit_clock,
  input wire frame_clock,
  input wire serial_audio_in,
  output reg [OUT_W-1:0] left_sample,
  output reg [OUT_W-1:0] right_sample,
  output reg sample_valid
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  wire bclk_s;
  wire lrck_s;
  wire data_s;
  reg bclk_d;
  reg lrck_seen;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [CNT_W-1:0] pos;
  reg [CNT_W-1:0] last_len;
  reg [CNT_W-1:0] wlen;
  reg chan_right;
  reg slot_right;
  reg edge_pend;
  reg got_left;
  reg [OUT_W-1:0] left_hold;
  reg take_bit;
  reg next_right;
  wire rise;
  wire frame_edge;
  wire slot_edge;
  wire is_i2s;
  wire is_lj;
  wire is_rj;
  wire [CNT_W-1:0] one_pos;
  wire [OUT_W-1:0] slot_word;
  wire [CNT_W-1:0] start_pos;

  // all three link lines are from another domain, so each is synchronised
  asr_sync u_sync_bclk (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .async_in(bit_clock), .sync_out(bclk_s)
  );
  asr_sync u_sync_lrck (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .async_in(frame_clock), .sync_out(lrck_s)
  );
  asr_sync u_sync_data (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .async_in(serial_audio_in), .sync_out(data_s)
  );

  // same sync delay on all lines keeps data aligned to its bit clock rise
  assign rise = bclk_s & ~bclk_d;

  // framing decode; code 3 behaves as right-justified
  assign is_i2s = (format_sel == `ASR_FMT_I2S);
  assign is_lj = (format_sel == `ASR_FMT_LJ);
  assign is_rj = !is_i2s && !is_lj;
  assign one_pos = {{(CNT_W-1){1'b0}}, 1'b1};

  // configured word length
  always @* begin
    if (word_len_sel == `ASR_WL_16) begin
      wlen = `ASR_BITS_16;
    end else if (word_len_sel == `ASR_WL_20) begin
      wlen = `ASR_BITS_20;
    end else begin
      wlen = `ASR_BITS_24;
    end
  end

  // rj: skip leading bits so the word ends at the slot end
  assign start_pos = (last_len > wlen) ? last_len - wlen : {CNT_W{1'b0}};

  // channel from frame clock level, polarity per framing
  always @* begin
    if (format_sel == `ASR_FMT_I2S) begin
      next_right = lrck_s;
    end else begin
      next_right = ~lrck_s;
    end
  end

  // frame clock edge as seen at a bit clock rise
  assign frame_edge = rise && (next_right != chan_right);
  // i2s: the rise at the frame edge still carries the old slot's last bit,
  // so its slot opens one rise later; justified slots open at the edge
  assign slot_edge = is_i2s ? (rise && edge_pend) : frame_edge;

  // bit position decode for the current rise; slot rise is position 0
  always @* begin
    take_bit = 1'b0;
    if (slot_edge) begin
      if (is_rj) begin
        take_bit = (start_pos == {CNT_W{1'b0}});
      end else begin
        take_bit = 1'b1;
      end
    end else if (rise) begin
      if (is_rj) begin
        take_bit = (pos >= start_pos);
      end else begin
        take_bit = (pos < wlen);
      end
    end
  end

  // slot shifter; a slot edge clears it and may load the first bit
  asr_slot #(.OUT_W(OUT_W)) u_slot (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .clear(slot_edge),
    .take_bit(take_bit),
    .bit_in(data_s),
    .word(slot_word)
  );

  // state machine: wait for the first frame clock edge before trusting slots
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (lrck_seen && slot_edge) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sign extend a collected word of wlen bits to the output width
  function [OUT_W-1:0] sext;
    input [OUT_W-1:0] w;
    input [CNT_W-1:0] n;
    begin
      if (n == `ASR_BITS_16) begin
        sext = {{(OUT_W-16){w[15]}}, w[15:0]};
      end else if (n == `ASR_BITS_20) begin
        sext = {{(OUT_W-20){w[19]}}, w[19:0]};
      end else begin
        sext = w;
      end
    end
  endfunction

  // counters, channel tracking and sample output
  always @(posedge clock) begin
    if (!reset_n) begin
      bclk_d <= 1'b0;
      lrck_seen <= 1'b0;
      state <= ST_IDLE;
      pos <= {CNT_W{1'b0}};
      last_len <= {CNT_W{1'b0}};
      chan_right <= 1'b0;
      slot_right <= 1'b0;
      edge_pend <= 1'b0;
      got_left <= 1'b0;
      left_hold <= {OUT_W{1'b0}};
      left_sample <= {OUT_W{1'b0}};
      right_sample <= {OUT_W{1'b0}};
      sample_valid <= 1'b0;
    end else if (clock_enable) begin
      bclk_d <= bclk_s;
      state <= next_state;
      sample_valid <= 1'b0;
      if (rise) begin
        lrck_seen <= 1'b1;
        chan_right <= next_right;
        // only i2s delays its slot start by one bit clock
        edge_pend <= is_i2s && frame_edge;
        if (slot_edge) begin
          // slot length learnt from the last slot: 32, 48 or 64 per frame
          last_len <= pos;
          pos <= one_pos;
          // channel of the slot now opening; the closing one is slot_right
          slot_right <= is_i2s ? chan_right : next_right;
          if (state == ST_RUN) begin
            if (!slot_right) begin
              left_hold <= sext(slot_word, wlen);
              got_left <= 1'b1;
            end else if (got_left) begin
              // whole frame in: publish both together
              left_sample <= left_hold;
              right_sample <= sext(slot_word, wlen);
              sample_valid <= 1'b1;
              got_left <= 1'b0;
            end
          end
        end else if (pos != {CNT_W{1'b1}}) begin
          pos <= pos + one_pos;
        end
      end
    end
  end
endmodule // asr_receiver
`default_nettype wire

// ===== design/asr_slot.v
// one channel slot shifter: collects msb-first bits of a slot
`timescale 1ns/10ps
`default_nettype none
module asr_slot #(
  parameter OUT_W = 24
) (
  input wire clock,
  input wire reset_n,
  input wire clock_enable,
  input wire clear,
  input wire take_bit,
  input wire bit_in,
  output reg [OUT_W-1:0] word
);
  // shift in msb first; clear starts a new slot
  always @(posedge clock) begin
    if (!reset_n) begin
      word <= {OUT_W{1'b0}};
    end else if (clock_enable) begin
      if (clear) begin
        // a slot may open with its first bit, so clear can load it
        word <= take_bit ? {{(OUT_W-1){1'b0}}, bit_in} : {OUT_W{1'b0}};
      end else if (take_bit) begin
        word <= {word[OUT_W-2:0], bit_in};
      end
    end
  end
endmodule // asr_slot
`default_nettype wire

// ===== design/asr_sync.v
// two flip-flop synchroniser for one external level
`timescale 1ns/10ps
`default_nettype none
module asr_sync (
  input wire clock,
  input wire reset_n,
  input wire clock_enable,
  input wire async_in,
  output reg sync_out
);
  reg meta;

  // first stage feeds only the second stage
  always @(posedge clock) begin
    if (!reset_n) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else if (clock_enable) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // asr_sync
`default_nettype wire

// ===== dv/asr_props.sv
// assertion checker for the serial audio receiver
`timescale 1ns/10ps
`default_nettype none
module asr_props #(
  parameter OUT_W = 24
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [1:0] format_sel,
  input wire logic [1:0] word_len_sel,
  input wire logic frame_clock,
  input wire logic [OUT_W-1:0] left_sample,
  input wire logic [OUT_W-1:0] right_sample,
  input wire logic sample_valid
);
  logic fc_q;
  logic [7:0] gap;
  logic [7:0] age;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // saturating ages since last valid and since frame clock moved
  always @(posedge clock) begin
    fc_q <= frame_clock;
    gap <= sample_valid ? 8'h00 : (gap == 8'hFF || !reset_n) ? 8'hFF : gap + 8'h01;
    age <= (frame_clock != fc_q) ? 8'h00 : (age == 8'hFF || !reset_n) ? 8'hFF : age + 8'h01;
  end
  a_valid_one_cycle: assert property (sample_valid |=> !sample_valid)
    else $error("valid too long");
  a_one_per_frame: assert property (sample_valid |-> gap > 8'hC8)
    else $error("valid too soon");
  a_valid_at_edge: assert property (sample_valid |-> age < 8'h14)
    else $error("valid away from frame edge");
  a_samples_hold: assert property (!sample_valid |-> $stable(left_sample) && $stable(right_sample))
    else $error("samples moved");
  a_sext_sixteen: assert property (sample_valid && word_len_sel == 2'h0 |-> $signed(left_sample) == $signed(left_sample[15:0]) && $signed(right_sample) == $signed(right_sample[15:0]))
    else $error("16-bit not sign extended");
  a_sext_twenty: assert property (sample_valid && word_len_sel == 2'h1 |-> $signed(left_sample) == $signed(left_sample[19:0]) && $signed(right_sample) == $signed(right_sample[19:0]))
    else $error("20-bit not sign extended");
  a_i2s_left_low: assert property (sample_valid && format_sel == 2'h0 |-> !frame_clock)
    else $error("i2s left level");
  a_just_left_high: assert property (sample_valid && format_sel != 2'h0 |-> frame_clock)
    else $error("justified left level");
  c_i2s: cover property (sample_valid && format_sel == 2'h0);
  c_lj: cover property (sample_valid && format_sel == 2'h1);
  c_rj: cover property (sample_valid && format_sel == 2'h2);
endmodule // asr_props
bind asr_receiver asr_props #(.OUT_W(OUT_W)) u_props (.clock(clock), .reset_n(reset_n),
  .format_sel(format_sel), .word_len_sel(word_len_sel), .frame_clock(frame_clock),
  .left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid));
`default_nettype wire

// ===== dv/asr_src_model.sv
// serial audio source model: bit clock, frame clock and data
`timescale 1ns/10ps
`default_nettype none
module asr_src_model (
  output logic bit_clock,
  output logic frame_clock,
  output logic serial_audio_in
);
  initial begin
    bit_clock = 1'b0;
    frame_clock = 1'b0;
    serial_audio_in = 1'b0;
  end
  // three frames; bit clock rests low between calls
  task automatic frames(input logic [1:0] fmt, input int slot, wl, input logic [23:0] l, r);
    int n;
    int m;
    int p;
    logic [23:0] w;
    for (n = 0; n < 6 * slot; n++) begin
      // i2s lags the justified stream by one bit
      m = (fmt == 2'h0) ? n + 2 * slot - 1 : n;
      p = m % slot - ((fmt == 2'h2) ? slot - wl : 0);
      w = ((m / slot) % 2 == 1) ? r : l;
      bit_clock = 1'b0;
      frame_clock = ((n / slot) % 2 == 1) ^ (fmt != 2'h0);
      // unused bits toggle so masking is exercised
      serial_audio_in = (p >= 0 && p < wl) ? w[wl-1-p] : n[0];
      #160;
      bit_clock = 1'b1;
      #160;
    end
    bit_clock = 1'b0;
    serial_audio_in = ~serial_audio_in;
  endtask
endmodule // asr_src_model
`default_nettype wire

// ===== dv/test_asr_receiver.sv
// testbench for the serial audio receiver
`timescale 1ns/10ps
`default_nettype none
module test_asr_receiver;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic [1:0] wl = 2'h2;
  logic bclk;
  logic fclk;
  logic sdata;
  logic [23:0] left;
  logic [23:0] right;
  logic valid;
  int fails = 0;
  int checks_done = 0;
  always #20 clock = ~clock;
  asr_src_model u_src (.bit_clock(bclk), .frame_clock(fclk), .serial_audio_in(sdata));
  asr_receiver u_dut (.clock(clock), .reset_n(reset_n), .clock_enable(1'b1),
    .format_sel(fmt), .word_len_sel(wl), .bit_clock(bclk), .frame_clock(fclk),
    .serial_audio_in(sdata), .left_sample(left), .right_sample(right), .sample_valid(valid));
  task automatic chk(input logic [23:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // selects change at a falling edge; link phase offset on purpose
  task automatic run(input logic [1:0] f, w, input int slot, bits, input logic [23:0] l, r);
    // reset between framings so no half frame of the old one is published
    @(negedge clock);
    reset_n = 1'b0;
    fmt = f;
    wl = w;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    #7;
    u_src.frames(f, slot, bits, l, r);
  endtask
  task automatic s_i2s_64_24;
    run(2'h0, 2'h2, 32, 24, 24'hA50F3C, 24'h123456);
    chk(left, 24'hA50F3C);
    chk(right, 24'h123456);
  endtask
  task automatic s_i2s_32_16;
    run(2'h0, 2'h0, 16, 16, 24'h008001, 24'h007FFE);
    chk(left, 24'hFF8001);
    chk(right, 24'h007FFE);
  endtask
  task automatic s_lj_48_24;
    run(2'h1, 2'h2, 24, 24, 24'h800000, 24'h7FFFFF);
    chk(left, 24'h800000);
    chk(right, 24'h7FFFFF);
  endtask
  task automatic s_lj_64_20;
    run(2'h1, 2'h1, 32, 20, 24'h0C3A5F, 24'h00F00F);
    chk(left, 24'hFC3A5F);
    chk(right, 24'h00F00F);
  endtask
  task automatic s_rj_64_24;
    run(2'h2, 2'h2, 32, 24, 24'hFEDCBA, 24'h010203);
    chk(left, 24'hFEDCBA);
    chk(right, 24'h010203);
  endtask
  task automatic s_rj_32_16;
    run(2'h2, 2'h0, 16, 16, 24'h009ABC, 24'h004321);
    chk(left, 24'hFF9ABC);
    chk(right, 24'h004321);
  endtask
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    s_i2s_64_24();
    s_i2s_32_16();
    s_lj_48_24();
    s_lj_64_20();
    s_rj_64_24();
    s_rj_32_16();
    final_report();
  end
  // all scenarios need about 0.3 ms
  initial begin
    #1000000;
    fails++;
    final_report();
  end
endmodule // test_asr_receiver
`default_nettype wire
